// ---- hdl/add_and_call_clear_execute.sv ----
// Execute stage for add, and, call and clear-memory operations
// Notes on behaviour
// RQ1: Carry add to work: work = work + mem + carry, update four arithmetic flags.
// RQ2: Carry add to memory: memory byte = work + mem + carry, update four flags.
// RQ3: Add memory to work without carry-in, update four arithmetic flags.
// RQ4: Add literal to work without carry-in, update four arithmetic flags.
// RQ5: Add to memory: memory byte = work + mem, update four flags.
// RQ6: AND memory into work; only the zero flag changes.
// RQ7: AND literal into work; only the zero flag changes.
// RQ8: AND to memory writes work AND mem back; work unchanged.
// RQ9: Call pushes program counter plus one onto the return stack.
// RQ10: Call loads target into program counter; no flag changes.
// RQ11: Call takes two instruction cycles.
// RQ12: Clear memory writes 00 to the byte; flags unchanged.
// RQ13: Carry from bit 7, nibble carry from bit 3, signed overflow, zero.
// RQ14: Operands are 8 bits; sums truncated to 8 bits.
`timescale 1ns/1ps
module add_and_call_clear_execute (
    input  wire logic                           i_ref_clk,
    input  wire logic                           i_arst_n,
    input  wire logic                           i_valid,
    input  wire alu_exec_pkg::req_s             i_req,
    output logic                                o_busy,
    output logic                                o_done,
    output logic [7:0]                          o_work_register,
    output alu_exec_pkg::flags_s                o_flags,
    output logic [alu_exec_pkg::PC_W-1:0]       o_pc,
    output logic                                o_mem_we,
    output logic [7:0]                          o_mem_wdata,
    output logic                                o_stack_push,
    output logic [alu_exec_pkg::PC_W-1:0]       o_stack_data
);

    // Whole block state and its next value
    alu_exec_pkg::state_s state_reg;
    alu_exec_pkg::state_s state_next;

    // Adder result with flags; 8-bit sum, carry out of bit 7 kept in the flags
    typedef struct packed {
        logic [7:0]           sum;
        alu_exec_pkg::flags_s flags;
    } add_s;

    // Shared by all five add forms so their flags always agree
    function automatic add_s add8(
        input logic [7:0] a,
        input logic [7:0] b,
        input logic       cin
    );
        logic [8:0] full;
        logic [4:0] low;
        add_s       r;
        // Wide sum for carry, low nibble sum for nibble carry
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        // Result cut to a byte, flags from the same sums
        r.sum = full[7:0]; // RQ14
        r.flags.carry_flag = full[8]; // RQ13
        r.flags.nibble_carry_flag = low[alu_exec_pkg::NIBBLE_BIT]; // RQ13
        r.flags.twos_complement_range_flag = (a[7] == b[7]) && (full[7] != a[7]); // RQ13
        r.flags.zero_flag = (full[7:0] == alu_exec_pkg::ZERO_BYTE); // RQ13
        return r;
    endfunction

    // AND result with its zero test in the top bit; shared by three ops
    function automatic logic [8:0] and8(
        input logic [7:0] a,
        input logic [7:0] b
    );
        logic [7:0] v;
        v = a & b;
        return {v == alu_exec_pkg::ZERO_BYTE, v};
    endfunction

    // Next-state: one instruction per accepted request, call stalls a cycle
    always_comb begin
        add_s       res;
        logic [8:0] andz;
        res  = '0;
        andz = '0;
        // Strobes drop unless this cycle's op raises them
        state_next           = state_reg;
        state_next.mem_we    = 1'b0;
        state_next.push      = 1'b0;
        state_next.done      = 1'b0;
        unique case (state_reg.state)
            // Ready for a new instruction
            alu_exec_pkg::ST_IDLE: begin
                if (i_valid) begin
                    state_next.done = 1'b1;
                    unique case (i_req.op)
                        // Carry add into the work register
                        alu_exec_pkg::OP_ADD_WITH_CARRY_TO_WORK: begin
                            res = add8(state_reg.work_register, i_req.mem_data, state_reg.flags.carry_flag);
                            state_next.work_register = res.sum; // RQ1
                            state_next.flags = res.flags; // RQ1
                        end

                        // Carry add written back to the byte
                        alu_exec_pkg::OP_ADD_WITH_CARRY_TO_MEMORY: begin
                            res = add8(state_reg.work_register, i_req.mem_data, state_reg.flags.carry_flag);
                            state_next.mem_we    = 1'b1; // RQ2
                            state_next.mem_wdata = res.sum;
                            state_next.flags     = res.flags; // RQ2
                        end

                        // Plain add of the memory byte
                        alu_exec_pkg::OP_ADD_MEM_TO_WORK: begin
                            res = add8(state_reg.work_register, i_req.mem_data, 1'b0);
                            state_next.work_register = res.sum; // RQ3
                            state_next.flags = res.flags; // RQ3
                        end

                        // Plain add of the literal
                        alu_exec_pkg::OP_ADD_IMM_TO_WORK: begin
                            res = add8(state_reg.work_register, i_req.literal, 1'b0);
                            state_next.work_register = res.sum; // RQ4
                            state_next.flags = res.flags; // RQ4
                        end

                        // Plain add written back to the byte
                        alu_exec_pkg::OP_ADD_TO_MEMORY: begin
                            res = add8(state_reg.work_register, i_req.mem_data, 1'b0);
                            state_next.mem_we    = 1'b1; // RQ5
                            state_next.mem_wdata = res.sum;
                            state_next.flags     = res.flags; // RQ5
                        end

                        // AND of the memory byte; only zero moves
                        alu_exec_pkg::OP_AND_MEM_TO_WORK: begin
                            andz = and8(state_reg.work_register, i_req.mem_data);
                            state_next.work_register   = andz[7:0]; // RQ6
                            state_next.flags.zero_flag = andz[8]; // RQ6
                        end

                        // AND of the literal; only zero moves
                        alu_exec_pkg::OP_AND_IMM_TO_WORK: begin
                            andz = and8(state_reg.work_register, i_req.literal);
                            state_next.work_register   = andz[7:0]; // RQ7
                            state_next.flags.zero_flag = andz[8]; // RQ7
                        end

                        // AND written back to the byte
                        alu_exec_pkg::OP_AND_TO_MEMORY: begin
                            // Flag effect not defined for this form, so flags are held
                            andz = and8(state_reg.work_register, i_req.mem_data);
                            state_next.mem_we    = 1'b1; // RQ8
                            state_next.mem_wdata = andz[7:0]; // RQ8
                        end

                        // Push the return address, jump, stall one cycle
                        alu_exec_pkg::OP_CALL: begin
                            state_next.push      = 1'b1; // RQ9
                            state_next.push_data = state_reg.pc + 1'b1; // RQ9
                            state_next.pc        = i_req.target; // RQ10
                            state_next.state     = alu_exec_pkg::ST_CALL_REDIRECT; // RQ11
                            state_next.done      = 1'b0;
                        end

                        // Clear the byte; flags and work kept
                        alu_exec_pkg::OP_ZERO_MEMORY_BYTE: begin
                            state_next.mem_we    = 1'b1; // RQ12
                            state_next.mem_wdata = alu_exec_pkg::ZERO_BYTE; // RQ12
                        end

                        // No operation: only the program counter moves
                        alu_exec_pkg::OP_NONE: begin
                            state_next.pc = state_reg.pc + 1'b1;
                        end

                        // Unused codes finish like a no-op
                        default: begin
                            state_next.done = 1'b1;
                        end
                    endcase

                    // Straight-line ops advance the program counter
                    if (i_req.op != alu_exec_pkg::OP_CALL && i_req.op != alu_exec_pkg::OP_NONE) begin
                        state_next.pc = state_reg.pc + 1'b1;
                    end
                end
            end

            // Second call cycle
            alu_exec_pkg::ST_CALL_REDIRECT: begin
                // Fetch refill at the target, requests are held off
                state_next.state = alu_exec_pkg::ST_IDLE; // RQ11
                state_next.done  = 1'b1; // RQ11
            end
        endcase
    end

    // Single state register; reset loads constants only
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= '{
                state:         alu_exec_pkg::ST_IDLE,
                work_register: alu_exec_pkg::WORK_RESET,
                flags:         '0,
                pc:            '0,
                mem_we:        1'b0,
                mem_wdata:     8'h00,
                push:          1'b0,
                push_data:     '0,
                done:          1'b0
            };
        end else begin
            state_reg <= state_next;
        end
    end

    // Handshake output, combinational from the state
    assign o_busy          = (state_reg.state == alu_exec_pkg::ST_CALL_REDIRECT);

    // Strobes, each high for one cycle per event
    assign o_done          = state_reg.done;
    assign o_mem_we        = state_reg.mem_we;
    assign o_stack_push    = state_reg.push;

    // Data outputs, held until the next update
    assign o_work_register = state_reg.work_register;
    assign o_flags         = state_reg.flags;
    assign o_pc            = state_reg.pc;
    assign o_mem_wdata     = state_reg.mem_wdata;
    assign o_stack_data    = state_reg.push_data;

endmodule

// ---- hdl/alu_exec_pkg.sv ----
// Shared types and constants for the add/and/call/clear execute datapath
package alu_exec_pkg;

    localparam int unsigned DATA_W      = 8;
    localparam int unsigned PC_W        = 10;
    localparam int unsigned CALL_CYCLES = 2;
    localparam logic [7:0]  ZERO_BYTE   = 8'h00;
    localparam logic [7:0]  WORK_RESET  = 8'h00;
    localparam int unsigned NIBBLE_BIT  = 4;

    // Operations this block executes
    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD_WITH_CARRY_TO_WORK,
        OP_ADD_WITH_CARRY_TO_MEMORY,
        OP_ADD_MEM_TO_WORK,
        OP_ADD_IMM_TO_WORK,
        OP_ADD_TO_MEMORY,
        OP_AND_MEM_TO_WORK,
        OP_AND_IMM_TO_WORK,
        OP_AND_TO_MEMORY,
        OP_CALL,
        OP_ZERO_MEMORY_BYTE
    } op_e;

    // Status flags
    typedef struct packed {
        logic twos_complement_range_flag;
        logic zero_flag;
        logic nibble_carry_flag;
        logic carry_flag;
    } flags_s;

    // Request from the decoder
    typedef struct packed {
        op_e              op;
        logic [7:0]       mem_data;
        logic [7:0]       literal;
        logic [PC_W-1:0]  target;
    } req_s;

    typedef enum logic {
        ST_IDLE,
        ST_CALL_REDIRECT
    } state_e;

    // Whole module state
    typedef struct packed {
        state_e           state;
        logic [7:0]       work_register;
        flags_s           flags;
        logic [PC_W-1:0]  pc;
        logic             mem_we;
        logic [7:0]       mem_wdata;
        logic             push;
        logic [PC_W-1:0]  push_data;
        logic             done;
    } state_s;

endpackage

// ---- sim/add_and_call_clear_execute_bench.sv ----
// Self-checking bench for the add/and/call/clear execute block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module add_and_call_clear_execute_bench;
    logic                          i_ref_clk = 1'b0;
    logic                          i_arst_n  = 1'b0;
    logic                          i_valid   = 1'b0;
    alu_exec_pkg::req_s            i_req     = '0;
    logic                          busy, done, mem_we, push;
    logic [7:0]                    work, wdata, mem_byte;
    alu_exec_pkg::flags_s          flags;
    logic [alu_exec_pkg::PC_W-1:0] pc, sdata, top, pc_exp = '0;
    int                            err_total = 0, checks_done = 0;

    always #5 i_ref_clk = ~i_ref_clk;

    add_and_call_clear_execute dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_valid(i_valid),
        .i_req(i_req), .o_busy(busy), .o_done(done), .o_work_register(work), .o_flags(flags), .o_pc(pc),
        .o_mem_we(mem_we), .o_mem_wdata(wdata), .o_stack_push(push), .o_stack_data(sdata));
    mem_stack_model far (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_we(mem_we), .i_wdata(wdata),
        .i_push(push), .i_push_data(sdata), .o_byte(mem_byte), .o_top(top));

    // One request, released after its taking edge; outputs settled at return
    task automatic step(input alu_exec_pkg::op_e op, input logic [7:0] m, lit, w, input logic [3:0] f,
                        input logic we, input logic [7:0] wd);
        @(negedge i_ref_clk);
        i_valid = 1'b1;
        i_req = '{op, m, lit, 10'h2A5};
        @(negedge i_ref_clk);
        i_valid = 1'b0;
        pc_exp++;
        `CHK("done", 1'b1, done)
        `CHK("work", w, work)
        `CHK("flags", f, flags)
        `CHK("pc", pc_exp, pc)
        `CHK("mem_we", we, mem_we)
        if (we) `CHK("wdata", wd, wdata)
    endtask

    task automatic test_add;
        step(alu_exec_pkg::OP_ADD_IMM_TO_WORK, 8'h00, 8'h7F, 8'h7F, 4'h0, 1'b0, 8'h00);
        step(alu_exec_pkg::OP_ADD_MEM_TO_WORK, 8'h01, 8'h00, 8'h80, 4'hA, 1'b0, 8'h00);
        step(alu_exec_pkg::OP_ADD_MEM_TO_WORK, 8'h80, 8'h00, 8'h00, 4'hD, 1'b0, 8'h00);
        $display("add test done");
    endtask

    // Carry left set before the memory form, so a dropped carry-in shows as 00
    task automatic test_carry;
        step(alu_exec_pkg::OP_ADD_WITH_CARRY_TO_WORK, 8'h0F, 8'h00, 8'h10, 4'h2, 1'b0, 8'h00);
        step(alu_exec_pkg::OP_ADD_TO_MEMORY, 8'hF0, 8'h00, 8'h10, 4'h5, 1'b1, 8'h00);
        step(alu_exec_pkg::OP_ADD_WITH_CARRY_TO_MEMORY, 8'hF0, 8'h00, 8'h10, 4'h1, 1'b1, 8'h01);
        $display("carry test done");
    endtask

    task automatic test_and;
        step(alu_exec_pkg::OP_AND_MEM_TO_WORK, 8'h30, 8'h00, 8'h10, 4'h1, 1'b0, 8'h00);
        step(alu_exec_pkg::OP_AND_TO_MEMORY, 8'h33, 8'h00, 8'h10, 4'h1, 1'b1, 8'h10);
        step(alu_exec_pkg::OP_AND_IMM_TO_WORK, 8'h00, 8'h0F, 8'h00, 4'h5, 1'b0, 8'h00);
        $display("and test done");
    endtask

    // Carry is set going in, so an add to memory that used it would show 06
    task automatic test_clear;
        step(alu_exec_pkg::OP_ZERO_MEMORY_BYTE, 8'hFF, 8'h00, 8'h00, 4'h5, 1'b1, 8'h00);
        step(alu_exec_pkg::OP_ADD_TO_MEMORY, 8'h05, 8'h00, 8'h00, 4'h0, 1'b1, 8'h05);
        @(negedge i_ref_clk);
        `CHK("mem_byte", 8'h05, mem_byte)
        `CHK("mem_we low", 1'b0, mem_we)
        $display("clear test done");
    endtask

    // A request held through the busy cycle must be ignored; zero flag set first so a touched flag shows
    task automatic test_call;
        step(alu_exec_pkg::OP_ADD_IMM_TO_WORK, 8'h00, 8'h00, 8'h00, 4'h4, 1'b0, 8'h00);
        step(alu_exec_pkg::OP_NONE, 8'hFF, 8'hFF, 8'h00, 4'h4, 1'b0, 8'h00);
        @(negedge i_ref_clk);
        i_valid = 1'b1;
        i_req = '{alu_exec_pkg::OP_CALL, 8'h00, 8'h00, 10'h2A5};
        @(negedge i_ref_clk);
        i_req = '{alu_exec_pkg::OP_ADD_IMM_TO_WORK, 8'h00, 8'h01, 10'h000};
        `CHK("push", 1'b1, push)
        `CHK("stack", pc_exp + 10'h1, sdata)
        `CHK("pc", 10'h2A5, pc)
        `CHK("busy", 1'b1, busy)
        `CHK("done", 1'b0, done)
        @(negedge i_ref_clk);
        i_valid = 1'b0;
        `CHK("done", 1'b1, done)
        `CHK("work", 8'h00, work)
        `CHK("flags", 4'h4, flags)
        `CHK("push low", 1'b0, push)
        `CHK("top", 10'h00E, top)
        $display("call test done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Whole run is about thirty cycles; far more means a hang
    initial begin
        #5000;
        err_total++;
        summarize();
    end

    initial begin
        repeat (2) @(negedge i_ref_clk);
        i_arst_n = 1'b1;
        test_add();
        test_carry();
        test_and();
        test_clear();
        test_call();
        summarize();
    end
endmodule

// ---- sim/add_and_call_clear_execute_props.sv ----
// Assertion checker for the add/and/call/clear execute block
`timescale 1ns/1ps
module add_and_call_clear_execute_props (
    input wire logic                          i_ref_clk,
    input wire logic                          i_arst_n,
    input wire logic                          i_valid,
    input wire alu_exec_pkg::req_s            i_req,
    input wire logic                          o_busy,
    input wire logic                          o_done,
    input wire logic [7:0]                    o_work_register,
    input wire alu_exec_pkg::flags_s          o_flags,
    input wire logic [alu_exec_pkg::PC_W-1:0] o_pc,
    input wire logic                          o_mem_we,
    input wire logic [7:0]                    o_mem_wdata,
    input wire logic                          o_stack_push,
    input wire logic [alu_exec_pkg::PC_W-1:0] o_stack_data
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    // Busy cycles never take a request, so they never arm a check
    wire logic take = i_valid && !o_busy;
    wire alu_exec_pkg::op_e op = i_req.op;

    a_call_push_next: assert property (take && op == alu_exec_pkg::OP_CALL
        |=> o_stack_push && o_stack_data == $past(o_pc) + 10'h1) else $error("call pushed wrong address");
    a_call_load_pc: assert property (take && op == alu_exec_pkg::OP_CALL
        |=> o_pc == $past(i_req.target) && $stable(o_flags)) else $error("call target or flags wrong");
    a_call_two_cycles: assert property (take && op == alu_exec_pkg::OP_CALL
        |=> o_busy && !o_done ##1 o_done && !o_busy) else $error("call did not take two cycles");
    a_clear_zero_byte: assert property (take && op == alu_exec_pkg::OP_ZERO_MEMORY_BYTE
        |=> o_mem_we && o_mem_wdata == 8'h00 && $stable(o_flags)) else $error("clear wrote wrong byte");
    a_adc_carry_in: assert property (take && op == alu_exec_pkg::OP_ADD_WITH_CARRY_TO_WORK
        |=> o_work_register == 8'($past(o_work_register) + $past(i_req.mem_data) + $past(o_flags.carry_flag)))
        else $error("carry add result wrong");
    a_add_mem_sum: assert property (take && op == alu_exec_pkg::OP_ADD_MEM_TO_WORK
        |=> {o_flags.carry_flag, o_work_register} == 9'($past(o_work_register)) + 9'($past(i_req.mem_data)))
        else $error("memory add result wrong");
    a_add_imm_sum: assert property (take && op == alu_exec_pkg::OP_ADD_IMM_TO_WORK
        |=> {o_flags.carry_flag, o_work_register} == 9'($past(o_work_register)) + 9'($past(i_req.literal)))
        else $error("literal add result wrong");
    a_and_zero_only: assert property (take && op == alu_exec_pkg::OP_AND_MEM_TO_WORK
        |=> o_work_register == ($past(o_work_register) & $past(i_req.mem_data))
        && o_flags.zero_flag == (o_work_register == 8'h00) && $stable(o_flags.carry_flag))
        else $error("and result or flags wrong");
    a_and_mem_keeps: assert property (take && op == alu_exec_pkg::OP_AND_TO_MEMORY
        |=> o_mem_we && o_mem_wdata == ($past(o_work_register) & $past(i_req.mem_data))
        && $stable(o_work_register)) else $error("and to memory wrong");
    a_add_with_carry_to_memory_mem_sum: assert property (take && op == alu_exec_pkg::OP_ADD_WITH_CARRY_TO_MEMORY
        |=> o_mem_we && $stable(o_work_register)
        && o_mem_wdata == 8'($past(o_work_register) + $past(i_req.mem_data) + $past(o_flags.carry_flag)))
        else $error("carry add to memory wrong");
    a_add_mem_write: assert property (take && op == alu_exec_pkg::OP_ADD_TO_MEMORY
        |=> o_mem_we && $stable(o_work_register)
        && {o_flags.carry_flag, o_mem_wdata} == 9'($past(o_work_register)) + 9'($past(i_req.mem_data)))
        else $error("add to memory wrong");
    a_and_imm_zero: assert property (take && op == alu_exec_pkg::OP_AND_IMM_TO_WORK
        |=> o_work_register == ($past(o_work_register) & $past(i_req.literal))
        && o_flags.zero_flag == (o_work_register == 8'h00) && $stable(o_flags.carry_flag))
        else $error("and literal result or flags wrong");

    // Main scenarios reached
    c_call: cover property (take && op == alu_exec_pkg::OP_CALL);
    c_add_mem: cover property (take && op == alu_exec_pkg::OP_ADD_TO_MEMORY);
    c_clear: cover property (take && op == alu_exec_pkg::OP_ZERO_MEMORY_BYTE);
endmodule

bind add_and_call_clear_execute add_and_call_clear_execute_props props (.*);

// ---- sim/mem_stack_model.sv ----
// Data memory byte and return stack model at the far side
`timescale 1ns/1ps
module mem_stack_model (
    input  wire logic                          i_ref_clk,
    input  wire logic                          i_arst_n,
    input  wire logic                          i_we,
    input  wire logic [7:0]                    i_wdata,
    input  wire logic                          i_push,
    input  wire logic [alu_exec_pkg::PC_W-1:0] i_push_data,
    output logic      [7:0]                    o_byte,
    output logic      [alu_exec_pkg::PC_W-1:0] o_top
);
    // Only the top stack entry is kept; nesting is not modelled
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_byte <= 8'h00;
            o_top  <= '0;
        end else begin
            if (i_we) o_byte <= i_wdata;
            if (i_push) o_top <= i_push_data;
        end
    end
endmodule
